// File: pkg/apdusr_pkg.sv
package apdusr_pkg;

  // ----------------------------------------------------------------
  // command header
  // ----------------------------------------------------------------
  localparam logic [7:0]  CLA_VAL       = 8'h00;
  localparam logic [7:0]  INS_SELECT    = 8'hA4;
  localparam logic [7:0]  INS_READ      = 8'hB0;
  localparam logic [7:0]  INS_WRITE     = 8'hD6;
  localparam logic [7:0]  P1_BY_FID     = 8'h00;
  localparam logic [7:0]  P1_EF         = 8'h02;
  localparam logic [7:0]  P1_BY_NAME    = 8'h04;
  localparam logic [7:0]  P2_NO_FCI     = 8'h0C;
  localparam logic [15:0] P1P2_EF       = 16'h020C;
  localparam logic [15:0] P1P2_APP      = 16'h0400;
  localparam logic [15:0] P1P2_FILE     = 16'h000C;
  localparam logic [8:0]  HDR_LEN       = 9'h005;

  // ----------------------------------------------------------------
  // lengths and identifiers
  // ----------------------------------------------------------------
  localparam logic [7:0]  LC_APP        = 8'h07;
  localparam logic [7:0]  LC_FILE       = 8'h02;
  localparam logic [7:0]  LE_APP        = 8'h00;
  localparam logic [7:0]  LE_RD_MIN     = 8'h01;
  localparam logic [7:0]  LE_RD_MAX     = 8'hFB;
  localparam logic [7:0]  LC_WR_MIN     = 8'h01;
  localparam logic [7:0]  LC_WR_MAX     = 8'hF8;
  localparam int          DBUF_DEPTH    = 7;
  localparam logic [55:0] APP_NAME      = 56'hD2760000850101;
  localparam logic [15:0] FID_CC        = 16'hE103;
  localparam logic [15:0] FID_NDEF      = 16'h0103;

  // ----------------------------------------------------------------
  // status words
  // ----------------------------------------------------------------
  localparam logic [15:0] SW_OK         = 16'h9000;
  localparam logic [15:0] SW_BAD_LEN    = 16'h6700;
  localparam logic [15:0] SW_BAD_DATA   = 16'h6A82;
  localparam logic [15:0] SW_BAD_P1P2   = 16'h6A86;
  localparam logic [15:0] SW_BAD_INS    = 16'h6D00;
  localparam logic [15:0] SW_BAD_CLA    = 16'h6E00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {FILE_NONE, FILE_APP, FILE_CC, FILE_NDEF, FILE_EF} apdusr_file_e;

endpackage : apdusr_pkg

// File: pkg/apdusr_resp_if.sv
`timescale 1ns/1ps
interface apdusr_resp_if;
  logic        start;
  logic        with_data;
  logic [15:0] addr;
  logic [7:0]  len;
  logic [15:0] sw;
  logic        done;

  modport ctrl (output start, output with_data, output addr, output len, output sw, input done);
  modport resp (input start, input with_data, input addr, input len, input sw, output done);
endinterface : apdusr_resp_if

// File: hdl/apdusr_responder.sv
`timescale 1ns/1ps
module apdusr_responder
  import apdusr_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  apdusr_resp_if.resp rif,
  output logic        fetch_req,
  output logic [15:0] fetch_addr,
  input  wire logic   fetch_valid,
  input  wire logic [7:0] fetch_data,
  output logic        out_valid,
  output logic [7:0]  out_data,
  output logic        out_last,
  input  wire logic   out_ready
);

  typedef enum logic [2:0] {RS_IDLE, RS_FETCH, RS_DATA, RS_SW1, RS_SW2} apdusr_rstate_e;

  typedef struct packed {
    apdusr_rstate_e st;
    logic [15:0]    addr;
    logic [7:0]     left;
    logic [7:0]     dat;
    logic [15:0]    sw;
    logic           done;
  } apdusr_resp_s;

  apdusr_resp_s s;
  apdusr_resp_s next_s;

  // ----------------------------------------------------------------
  // data bytes first, then the two status bytes
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    unique case (s.st)
      RS_IDLE: begin
        if (rif.start) begin
          next_s.addr = rif.addr;
          next_s.left = rif.len;
          next_s.sw   = rif.sw;
          // data only on normal completion and nonzero length
          if (rif.with_data && rif.sw == SW_OK && rif.len != 8'h00) begin // R14 R12
            next_s.st = RS_FETCH;
          end else begin
            next_s.st  = RS_SW1; // R18
            next_s.dat = rif.sw[15:8];
          end
        end
      end
      RS_FETCH: begin
        if (fetch_valid) begin
          next_s.dat = fetch_data;
          next_s.st  = RS_DATA;
        end
      end
      RS_DATA: begin
        if (out_ready) begin
          next_s.addr = s.addr + 16'h0001;
          next_s.left = s.left - 8'h01;
          if (s.left == 8'h01) begin // R12
            next_s.st  = RS_SW1;
            next_s.dat = s.sw[15:8];
          end else begin
            next_s.st = RS_FETCH;
          end
        end
      end
      RS_SW1: begin
        if (out_ready) begin
          next_s.st  = RS_SW2;
          next_s.dat = s.sw[7:0];
        end
      end
      RS_SW2: begin
        if (out_ready) begin
          next_s.st   = RS_IDLE;
          next_s.done = 1'b1;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // handshakes are decoded from state, data comes from the register
  assign fetch_req  = (s.st == RS_FETCH);
  assign fetch_addr = s.addr;
  assign out_valid  = (s.st == RS_DATA) || (s.st == RS_SW1) || (s.st == RS_SW2);
  assign out_data   = s.dat;
  assign out_last   = (s.st == RS_SW2);
  assign rif.done   = s.done;

endmodule : apdusr_responder

// File: hdl/apdusr_decoder.sv
// Function
// R1 - class byte must be zero, else error
// R2 - decode SELECT and its three P1 modes
// R3 - SELECT accepts only three P1,P2 pairs
// R4 - P2 0x0C gives status words only
// R5 - SELECT Lc seven for application, else two
// R6 - application name must match exactly
// R7 - file ids pick CC or NDEF file
// R8 - EF choice accepts any two-byte id
// R9 - reader avoids CC/NDEF ids for plain EF
// R10 - Le only on application select, zero
// R11 - decode READ, address from P1 and P2
// R12 - READ length 1 to 251, data first
// R13 - encrypted READ length sixteen times n; not checked, any READ length 1 to 251 is taken
// R14 - no data unless normal completion
// R15 - READ from memory or host by mode
// R16 - WRITE to memory or host by mode
// R17 - on error keep selection, status only
// R18 - SELECT answer is exactly two status bytes
`timescale 1ns/1ps
module apdusr_decoder
  import apdusr_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         tunnel_mode,
  input  wire logic         in_valid,
  input  wire logic [7:0]   in_data,
  input  wire logic         in_last,
  output logic              in_ready,
  output logic              out_valid,
  output logic [7:0]        out_data,
  output logic              out_last,
  input  wire logic         out_ready,
  output logic              mem_rd_req,
  output logic [15:0]       mem_rd_addr,
  input  wire logic         mem_rd_valid,
  input  wire logic [7:0]   mem_rd_data,
  output logic              host_rd_req,
  output logic [15:0]       host_rd_addr,
  input  wire logic         host_rd_valid,
  input  wire logic [7:0]   host_rd_data,
  output logic              mem_wr_valid,
  output logic              host_wr_valid,
  output logic [15:0]       wr_addr,
  output logic [7:0]        wr_data,
  output apdusr_file_e      selected
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  // asynchronous assert, two-flop release
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_RX, ST_EVAL, ST_WAIT} apdusr_state_e;

  typedef struct packed {
    apdusr_state_e                st;
    logic [8:0]                   idx;
    logic [7:0]                   cla;
    logic [7:0]                   ins;
    logic [7:0]                   p1;
    logic [7:0]                   p2;
    logic [7:0]                   b4;
    logic [7:0]                   tail;
    logic [DBUF_DEPTH-1:0][7:0]   dbuf;
    apdusr_file_e                 sel;
    logic                         tunnel;
    logic                         go;
    logic                         with_data;
    logic [15:0]                  sw;
    logic                         mem_wr;
    logic                         host_wr;
    logic [15:0]                  wr_addr;
    logic [7:0]                   wr_data;
  } apdusr_dec_s;

  apdusr_dec_s s;
  apdusr_dec_s next_s;

  // response carrier, declared here because the command logic reads its done strobe
  apdusr_resp_if rif ();

  // ----------------------------------------------------------------
  // capture, write forwarding and field checks
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] p1p2;
    logic [15:0] fid;
    logic [8:0]  off;
    logic [15:0] sw_v;
    logic        name_ok;
    logic        wr_len_ok;
    p1p2      = {s.p1, s.p2};
    fid       = {s.dbuf[0], s.dbuf[1]};
    off       = s.idx - HDR_LEN;
    sw_v      = SW_OK;
    name_ok   = 1'b1;
    wr_len_ok = (s.b4 >= LC_WR_MIN) && (s.b4 <= LC_WR_MAX);
    next_s         = s;
    next_s.go      = 1'b0;
    next_s.mem_wr  = 1'b0;
    next_s.host_wr = 1'b0;
    for (int i = 0; i < DBUF_DEPTH; i++) begin
      if (s.dbuf[i] != APP_NAME[55 - 8*i -: 8]) begin
        name_ok = 1'b0;
      end
    end
    unique case (s.st)
      ST_RX: begin
        if (in_valid) begin
          unique case (s.idx)
            9'd0: begin
              next_s.cla    = in_data;
              next_s.tunnel = tunnel_mode;
            end
            9'd1: next_s.ins = in_data;
            9'd2: next_s.p1  = in_data;
            9'd3: next_s.p2  = in_data;
            9'd4: next_s.b4  = in_data;
            default: begin
              if (off < 9'(DBUF_DEPTH)) begin
                next_s.dbuf[off[2:0]] = in_data;
              end
              if (off == {1'b0, s.b4}) begin
                next_s.tail = in_data;
              end
              // data goes straight through; no field check can stop it later
              if (s.cla == CLA_VAL && s.ins == INS_WRITE && wr_len_ok && off < {1'b0, s.b4}) begin // R1
                next_s.mem_wr  = !s.tunnel; // R16
                next_s.host_wr = s.tunnel; // R16
                next_s.wr_addr = p1p2 + {7'h00, off};
                next_s.wr_data = in_data;
              end
            end
          endcase
          if (s.idx != 9'h1FF) begin
            next_s.idx = s.idx + 9'h001;
          end
          if (in_last) begin
            next_s.st = ST_EVAL;
          end
        end
      end
      ST_EVAL: begin
        next_s.with_data = 1'b0;
        if (s.cla != CLA_VAL) begin
          sw_v = SW_BAD_CLA; // R1
        end else if (s.idx < HDR_LEN) begin
          sw_v = SW_BAD_LEN;
        end else begin
          unique case (s.ins)
            INS_SELECT: begin // R2
              if (p1p2 != P1P2_EF && p1p2 != P1P2_APP && p1p2 != P1P2_FILE) begin
                sw_v = SW_BAD_P1P2; // R3
              end else if (p1p2 == P1P2_APP) begin
                // optional Le must be zero
                if (s.b4 != LC_APP || !(s.idx == HDR_LEN + 9'(LC_APP) ||
                    (s.idx == HDR_LEN + 9'(LC_APP) + 9'd1 && s.tail == LE_APP))) begin
                  sw_v = SW_BAD_LEN; // R5 R10
                end else if (!name_ok) begin
                  sw_v = SW_BAD_DATA; // R6
                end else begin
                  next_s.sel = FILE_APP;
                end
              end else if (s.b4 != LC_FILE || s.idx != HDR_LEN + 9'(LC_FILE)) begin
                sw_v = SW_BAD_LEN; // R5 R10
              end else if (p1p2 == P1P2_FILE) begin
                // other ids fall back to a plain EF choice
                if (fid == FID_CC) begin
                  next_s.sel = FILE_CC; // R7
                end else if (fid == FID_NDEF) begin
                  next_s.sel = FILE_NDEF; // R7
                end else begin
                  next_s.sel = FILE_EF; // R9
                end
              end else begin
                next_s.sel = FILE_EF; // R8
              end
              // no FCI is ever returned, P2 0x0C or not
              next_s.with_data = 1'b0; // R4 R18
            end
            INS_READ: begin // R11
              if (s.idx != HDR_LEN || s.b4 < LE_RD_MIN || s.b4 > LE_RD_MAX) begin
                sw_v = SW_BAD_LEN; // R12
              end else begin
                next_s.with_data = 1'b1; // R12
              end
            end
            INS_WRITE: begin
              if (!wr_len_ok || s.idx != HDR_LEN + {1'b0, s.b4}) begin
                sw_v = SW_BAD_LEN;
              end
            end
            default: sw_v = SW_BAD_INS;
          endcase
        end
        // any failure keeps the old selection
        if (sw_v != SW_OK) begin
          next_s.sel       = s.sel; // R17
          next_s.with_data = 1'b0; // R17
        end
        next_s.sw = sw_v;
        next_s.go = 1'b1;
        next_s.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (rif.done) begin
          next_s.st  = ST_RX;
          next_s.idx = 9'h000;
        end
      end
      default: next_s.st = ST_RX;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // response path
  // ----------------------------------------------------------------
  logic        fetch_req;
  logic [15:0] fetch_addr;
  logic        fetch_valid;
  logic [7:0]  fetch_data;

  assign rif.start     = s.go;
  assign rif.with_data = s.with_data;
  assign rif.addr      = {s.p1, s.p2}; // R11
  assign rif.len       = s.b4;
  assign rif.sw        = s.sw;

  // read source follows the mode caught with the class byte
  assign mem_rd_req   = fetch_req && !s.tunnel; // R15
  assign host_rd_req  = fetch_req && s.tunnel; // R15
  assign mem_rd_addr  = fetch_addr;
  assign host_rd_addr = fetch_addr;
  assign fetch_valid  = s.tunnel ? host_rd_valid : mem_rd_valid;
  assign fetch_data   = s.tunnel ? host_rd_data : mem_rd_data;

  apdusr_responder u_resp (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .rif         (rif),
    .fetch_req   (fetch_req),
    .fetch_addr  (fetch_addr),
    .fetch_valid (fetch_valid),
    .fetch_data  (fetch_data),
    .out_valid   (out_valid),
    .out_data    (out_data),
    .out_last    (out_last),
    .out_ready   (out_ready)
  );

  // outputs; the receive side stalls while a command is answered
  assign in_ready      = (s.st == ST_RX);
  assign mem_wr_valid  = s.mem_wr;
  assign host_wr_valid = s.host_wr;
  assign wr_addr       = s.wr_addr;
  assign wr_data       = s.wr_data;
  assign selected      = s.sel;

endmodule : apdusr_decoder

// File: testbench/apdusr_rd_model.sv
`timescale 1ns/1ps
module apdusr_rd_model #(
  parameter logic [7:0] SALT = 8'h5A
) (
  input  wire logic        clk_sys,
  input  wire logic        req,
  input  wire logic [15:0] addr,
  output logic             valid,
  output logic [7:0]       data
);
  // ----------------------------------------------------------------
  // read source: memory or host, chosen by salt
  // ----------------------------------------------------------------
  logic [1:0] wait_cnt;

  initial begin
    valid    = 1'b0;
    data     = 8'h00;
    wait_cnt = 2'h0;
  end

  // answer a held request after 0..3 idle cycles, so prompt and slow both occur
  always @(posedge clk_sys) begin
    valid <= 1'b0;
    data  <= ~data; // released bus shows no stale byte
    if (req && !valid && wait_cnt == 2'h0) begin
      valid    <= 1'b1;
      data     <= addr[7:0] ^ SALT;
      wait_cnt <= addr[1:0];
    end else if (req && !valid) begin
      wait_cnt <= wait_cnt - 2'h1;
    end
  end
endmodule : apdusr_rd_model

// File: testbench/apdusr_decoder_chk.sv
`timescale 1ns/1ps
module apdusr_decoder_chk
  import apdusr_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         resetn,
  input wire logic         tunnel_mode,
  input wire logic         in_ready,
  input wire logic         out_valid,
  input wire logic [7:0]   out_data,
  input wire logic         out_last,
  input wire logic         out_ready,
  input wire logic         mem_rd_req,
  input wire logic [15:0]  mem_rd_addr,
  input wire logic         mem_rd_valid,
  input wire logic [7:0]   mem_rd_data,
  input wire logic         host_rd_req,
  input wire logic         host_rd_valid,
  input wire logic [7:0]   host_rd_data,
  input wire logic         mem_wr_valid,
  input wire logic         host_wr_valid,
  input wire apdusr_file_e selected
);
  // ----------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_mem_fetch;
    mem_rd_req && mem_rd_valid;
  endsequence
  sequence s_host_fetch;
    host_rd_req && host_rd_valid;
  endsequence
  sequence s_sw2_taken;
    out_valid && out_ready && out_last;
  endsequence

  property p_rd_hold;
    mem_rd_req && !mem_rd_valid |=> mem_rd_req && $stable(mem_rd_addr);
  endproperty
  property p_rf_source;
    mem_rd_req |-> !tunnel_mode && !host_rd_req;
  endproperty
  property p_tun_source;
    host_rd_req |-> tunnel_mode && !mem_rd_req;
  endproperty
  property p_mem_data;
    s_mem_fetch |=> out_valid && out_data == $past(mem_rd_data);
  endproperty
  property p_host_data;
    s_host_fetch |=> out_valid && out_data == $past(host_rd_data);
  endproperty
  property p_out_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last);
  endproperty
  property p_busy;
    out_valid |-> !in_ready;
  endproperty
  property p_sw2_end;
    s_sw2_taken |=> !out_valid ##1 (in_ready && !out_valid);
  endproperty
  // selection moves only together with a normal-completion status
  property p_sel_ok;
    !$stable(selected) |=> out_valid && out_data == SW_OK[15:8];
  endproperty
  property p_wr_route;
    mem_wr_valid || host_wr_valid |-> host_wr_valid == tunnel_mode && !(mem_wr_valid && host_wr_valid);
  endproperty

  a_rd_hold:    assert property (p_rd_hold)    else $error("read request dropped early");
  a_rf_source:  assert property (p_rf_source)  else $error("memory read outside rf mode");
  a_tun_source: assert property (p_tun_source) else $error("host read outside tunnel mode");
  a_mem_data:   assert property (p_mem_data)   else $error("memory byte not forwarded");
  a_host_data:  assert property (p_host_data)  else $error("host byte not forwarded");
  a_out_hold:   assert property (p_out_hold)   else $error("response byte changed while stalled");
  a_busy:       assert property (p_busy)       else $error("input taken during response");
  a_sw2_end:    assert property (p_sw2_end)    else $error("response did not end after last status");
  a_sel_ok:     assert property (p_sel_ok)     else $error("selection changed without success");
  a_wr_route:   assert property (p_wr_route)   else $error("write strobe on wrong side");
endmodule : apdusr_decoder_chk

bind apdusr_decoder apdusr_decoder_chk u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .tunnel_mode(tunnel_mode), .in_ready(in_ready),
  .out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_ready(out_ready),
  .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid),
  .mem_rd_data(mem_rd_data), .host_rd_req(host_rd_req), .host_rd_valid(host_rd_valid),
  .host_rd_data(host_rd_data), .mem_wr_valid(mem_wr_valid), .host_wr_valid(host_wr_valid),
  .selected(selected)
);

// File: testbench/apdusr_decoder_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module apdusr_decoder_tb_top;
  import apdusr_pkg::*;
  // ----------------------------------------------------------------
  // stimulus, partner models and scoreboard
  // ----------------------------------------------------------------
  logic         clk_sys, resetn, tunnel_mode, in_valid, in_last, in_ready, out_valid, out_last, out_ready;
  logic         mem_rd_req, mem_rd_valid, host_rd_req, host_rd_valid, mem_wr_valid, host_wr_valid;
  logic [7:0]   in_data, out_data, mem_rd_data, host_rd_data, wr_data, le;
  logic [15:0]  mem_rd_addr, host_rd_addr, wr_addr;
  logic [31:0]  rnd;
  logic [8:0]   exp_r;
  logic [24:0]  exp_w;
  logic [8:0]   rsp_q[$];
  logic [24:0]  wr_q[$];
  logic [15:0]  bad_pp[4] = '{16'h010C, 16'h0200, 16'h040C, 16'h0000};
  logic [7:0]   les[3] = '{8'h01, 8'hFB, 8'h00};
  apdusr_file_e selected;
  int           n_fail = 0;
  int           check_count = 0;

  apdusr_decoder DUT (
    .clk_sys(clk_sys), .resetn(resetn), .tunnel_mode(tunnel_mode), .in_valid(in_valid), .in_data(in_data),
    .in_last(in_last), .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .out_ready(out_ready), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid),
    .mem_rd_data(mem_rd_data), .host_rd_req(host_rd_req), .host_rd_addr(host_rd_addr),
    .host_rd_valid(host_rd_valid), .host_rd_data(host_rd_data), .mem_wr_valid(mem_wr_valid),
    .host_wr_valid(host_wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .selected(selected)
  );
  apdusr_rd_model #(.SALT(8'h5A)) u_mem (
    .clk_sys(clk_sys), .req(mem_rd_req), .addr(mem_rd_addr), .valid(mem_rd_valid), .data(mem_rd_data)
  );
  apdusr_rd_model #(.SALT(8'hA5)) u_host (
    .clk_sys(clk_sys), .req(host_rd_req), .addr(host_rd_addr), .valid(host_rd_valid), .data(host_rd_data)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // random sink stalls, changed just after each edge
  always @(posedge clk_sys) begin
    #1 out_ready = ($urandom % 4) != 0;
  end

  // checked half a cycle ahead of the taking edge, where all is settled
  always @(negedge clk_sys) begin
    if (out_valid && out_ready) begin
      exp_r = (rsp_q.size() != 0) ? rsp_q.pop_front() : 9'bx;
      `CHK({out_last, out_data}, exp_r)
    end
    if (mem_wr_valid || host_wr_valid) begin
      exp_w = (wr_q.size() != 0) ? wr_q.pop_front() : 25'bx;
      `CHK({host_wr_valid, wr_addr, wr_data}, exp_w)
    end
  end

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic step(inout int n);
    @(posedge clk_sys);
    #1;
    n++;
  endtask : step

  // one command, bytes packed high first; expectations noted before driving
  task automatic cmd(input logic [103:0] v, input int len, input logic [15:0] sw, input apdusr_file_e es,
                     input logic tun);
    logic [7:0] b[13];
    logic [7:0] salt;
    int         n;
    for (int k = 0; k < len; k++) b[k] = v[8 * (len - 1 - k) +: 8];
    salt = tun ? 8'hA5 : 8'h5A;
    if (sw === SW_OK && b[1] === INS_READ)
      for (int i = 0; i < b[4]; i++) rsp_q.push_back({1'b0, 8'({b[2], b[3]} + 16'(i)) ^ salt});
    if (sw === SW_OK && b[1] === INS_WRITE)
      for (int i = 0; i < b[4]; i++) wr_q.push_back({tun, {b[2], b[3]} + 16'(i), b[5 + i]});
    rsp_q.push_back({1'b0, sw[15:8]});
    rsp_q.push_back({1'b1, sw[7:0]});
    tunnel_mode = tun;
    for (int k = 0; k < len; k++) begin
      in_valid = 1'b1;
      in_data  = b[k];
      in_last  = (k == len - 1);
      n = 0;
      while (!in_ready && n < 1000) step(n);
      if (n >= 1000) begin
        n_fail++;
        conclude();
      end
      @(posedge clk_sys);
      #1;
    end
    in_valid = 1'b0;
    in_last  = 1'b0;
    n = 0;
    while ((rsp_q.size() != 0 || !in_ready) && n < 3000) step(n);
    if (n >= 3000) begin
      n_fail++;
      conclude();
    end
    `CHK(selected, es)
  endtask : cmd

  initial begin
    rnd = $urandom(32'h9691);
    resetn      = 1'b0;
    tunnel_mode = 1'b0;
    in_valid    = 1'b0;
    in_data     = 8'h00;
    in_last     = 1'b0;
    out_ready   = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    rnd = $urandom;
    cmd({40'h00A4020C02, rnd[15:0]}, 7, SW_OK, FILE_EF, 1'b0);
    cmd(56'h00A4000C02E103, 7, SW_OK, FILE_CC, 1'b0);
    cmd(56'h80A4000C020103, 7, SW_BAD_CLA, FILE_CC, 1'b0);
    cmd(56'h00A4000C021234, 7, SW_OK, FILE_EF, 1'b0);
    cmd(56'h00A4000C020103, 7, SW_OK, FILE_NDEF, 1'b0);
    foreach (bad_pp[i]) cmd({16'h00A4, bad_pp[i], 24'h02E103}, 7, SW_BAD_P1P2, FILE_NDEF, 1'b0);
    cmd(64'h00A4000C03E10300, 8, SW_BAD_LEN, FILE_NDEF, 1'b0);
    cmd(56'h00A4040002E103, 7, SW_BAD_LEN, FILE_NDEF, 1'b0);
    cmd(104'h00A4040007D2760000850102_00, 13, SW_BAD_DATA, FILE_NDEF, 1'b0);
    cmd(104'h00A4040007D2760000850101_01, 13, SW_BAD_LEN, FILE_NDEF, 1'b0);
    cmd(104'h00A4040007D2760000850101_00, 13, SW_OK, FILE_APP, 1'b0);
    cmd(64'h00A4020C02123400, 8, SW_BAD_LEN, FILE_APP, 1'b0);
    cmd(40'h00CA000000, 5, SW_BAD_INS, FILE_APP, 1'b0);
    for (int m = 0; m < 2; m++) begin
      foreach (les[j]) begin
        rnd = $urandom;
        le  = (les[j] != 8'h00) ? les[j] : 8'(1 + rnd[20:16]);
        cmd({16'h00B0, rnd[15:0], le}, 5, SW_OK, FILE_APP, m[0]);
      end
      rnd = $urandom;
      cmd({16'h00D6, rnd[15:0], 8'h03, rnd[23:0]}, 8, SW_OK, FILE_APP, m[0]);
    end
    cmd({16'h00B0, 16'h0100, 8'hF0}, 5, SW_OK, FILE_APP, 1'b1);
    cmd(40'h00B0001000, 5, SW_BAD_LEN, FILE_APP, 1'b0);
    cmd(40'h00B00010FC, 5, SW_BAD_LEN, FILE_APP, 1'b1);
    cmd(40'h80B0001004, 5, SW_BAD_CLA, FILE_APP, 1'b0);
    conclude();
  end
endmodule : apdusr_decoder_tb_top
